// *** awf_pkg.sv ***
`default_nettype none
package awf_pkg;
   localparam int STAT_W = 16;
   localparam int SAMPLE_W = 24;
   localparam int WORD_W = 32;
   localparam int WORD_MSB = WORD_W - 1;
   localparam int HAM_W = 8;
   localparam int PAR_N = 5;
   localparam int DATA_N = 24;
   // hamming byte layout
   localparam int HB_PAR_LSB = 3;
   localparam int HB_CHK1 = 2;
   localparam int HB_CHK0 = 1;
   localparam int HB_ZERO = 0;
   // mclk cycles the strap synchronisers need before the straps are taken
   localparam int STRAP_SETTLE = 3;
   // host cs_n setup and hold, in mclk cycles; covers the far end's cs_n synchroniser
   localparam int CS_SETUP_CYC = 4;
   localparam int CS_HOLD_CYC = 4;
   localparam logic [5:0] BITS16 = 6'h10;
   localparam logic [5:0] BITS24 = 6'h18;
   localparam logic [5:0] BITS32 = 6'h20;

   typedef enum logic [1:0] {AWF_WL16, AWF_WL24, AWF_WL32} awf_wl_t;

   typedef struct packed {
      logic dbl;
      logic sgl;
      logic [DATA_N-1:0] field;
   } awf_dec_t;

   function automatic logic [5:0] wl_bits(input awf_wl_t wl);
      case (wl)
         AWF_WL24: return BITS24;
         AWF_WL32: return BITS32;
         default: return BITS16;
      endcase
   endfunction : wl_bits

   // [RULE17] [RULE18] position map
   // encoded position of data bit i; parity slots 1,2,4,8,16 are skipped
   function automatic logic [4:0] ham_pos(input int i);
      int p;
      p = 29 - i - (i > 12 ? 1 : 0) - (i > 19 ? 1 : 0) - (i > 22 ? 1 : 0);
      return 5'(p);
   endfunction : ham_pos

   // [RULE14] [RULE20] [RULE22] even parity byte
   function automatic logic [HAM_W-1:0] ham_encode(input logic [DATA_N-1:0] d);
      logic [PAR_N-1:0] p;
      logic [4:0] pos;
      logic ov;
      logic [HAM_W-1:0] b;
      p = '0;
      for (int i = 0; i < DATA_N; i++) begin
         pos = ham_pos(i);
         for (int k = 0; k < PAR_N; k++) begin
            if (pos[k]) begin
               p[k] = p[k] ^ d[i];
            end
         end
      end
      ov = (^d) ^ (^p);
      b = '0;
      b[HB_PAR_LSB +: PAR_N] = p;
      b[HB_CHK1] = ov;
      b[HB_CHK0] = ov;
      b[HB_ZERO] = 1'b0;
      return b;
   endfunction : ham_encode

   function automatic awf_dec_t ham_decode(input logic [DATA_N-1:0] d, input logic [HAM_W-1:0] b);
      awf_dec_t r;
      logic [HAM_W-1:0] e;
      logic [PAR_N-1:0] syn;
      logic ov;
      e = ham_encode(d);
      syn = e[HB_PAR_LSB +: PAR_N] ^ b[HB_PAR_LSB +: PAR_N];
      ov = (^d) ^ (^b[HB_PAR_LSB +: PAR_N]) ^ b[HB_CHK1];
      r.field = d;
      r.sgl = 1'b0;
      r.dbl = 1'b0;
      if (ov) begin
         // odd error count: one flip, located by the syndrome
         r.sgl = 1'b1;
         for (int i = 0; i < DATA_N; i++) begin
            if (ham_pos(i) == syn) begin
               r.field[i] = ~d[i];
            end
         end
      end else if (syn != '0) begin
         r.dbl = 1'b1;
      end
      return r;
   endfunction : ham_decode

   // left-aligned device word from a 24-bit field; 16-bit content sits in field[23:8]
   function automatic logic [WORD_MSB:0] build_word(input logic [DATA_N-1:0] f, input awf_wl_t wl,
                                                    input logic ham);
      logic [DATA_N-1:0] t;
      t = {f[DATA_N-1:8], 8'h00};
      case (wl)
         AWF_WL24: return ham ? {f[DATA_N-1:8], ham_encode(t), 8'h00} : {f, 8'h00};
         AWF_WL32: return {f, ham ? ham_encode(f) : 8'h00};
         default: return {f[DATA_N-1:8], 16'h0000};
      endcase
   endfunction : build_word

   function automatic awf_dec_t split_word(input logic [WORD_MSB:0] w, input awf_wl_t wl, input logic ham);
      awf_dec_t r;
      if (ham && wl == AWF_WL24) begin
         r = ham_decode({w[WORD_MSB:16], 8'h00}, w[15:8]);
      end else if (ham && wl == AWF_WL32) begin
         r = ham_decode(w[WORD_MSB:8], w[7:0]);
      end else begin
         r.field = w[WORD_MSB:8];
         r.sgl = 1'b0;
         r.dbl = 1'b0;
      end
      return r;
   endfunction : split_word
endpackage : awf_pkg
`default_nettype wire

// *** awf_link_if.sv ***
`default_nettype none
interface awf_link_if;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;
   logic dout_oe;
   logic dout_line;
   // undriven line reads low
   assign dout_line = dout_oe & dout;
   modport dev (input sclk, input cs_n, input din, output dout, output dout_oe);
   modport host (output sclk, output cs_n, output din, input dout_line);
endinterface : awf_link_if
`default_nettype wire

// *** awf_device.sv ***
// Functional notes
// [RULE1] first host word is the command
// [RULE2] host puts command in top 16 bits
// [RULE3] status word leads every device frame
// [RULE4] one word per channel follows status
// [RULE5] truncate to 16 bits when required
// [RULE6] 24-bit protected: 16 data, 8 hamming
// [RULE7] 16-bit results two's complement, clipped
// [RULE8] 24-bit results two's complement, clipped
// [RULE9] 32-bit: 24 data, hamming or zeros
// [RULE10] protection strap enables hamming
// [RULE11] hamming not allowed with 16-bit words
// [RULE12] status and command are 16 bits
// [RULE13] hamming byte ends every word
// [RULE14] byte: five parity, two checksum, zero
// [RULE15] fix single errors, flag double errors
// [RULE16] crc excludes hamming byte
// [RULE17] parity positions and coverage pattern
// [RULE18] data and parity bit ordering
// [RULE19] word-length strap latched once after reset
// [RULE20] parity bits are even parity
// [RULE21] 16-bit data padded with zero positions
// [RULE22] checksum is overall parity
`default_nettype none
module awf_device
   import awf_pkg::*;
#(
   parameter int NCH = 4
) (
   input wire logic mclk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic word_length_strap_level, // strap tied high
   input wire logic word_length_strap_float, // strap left open
   input wire logic protection_enable_strap_level, // strap tied high
   input wire logic protection_enable_strap_float, // strap left open
   input wire logic [STAT_W-1:0] status_word, // status content for next frame
   input wire logic [NCH*SAMPLE_W-1:0] samples, // channel results, channel 0 low
   output logic [STAT_W-1:0] cmd_word, // last received command
   output logic cmd_valid, // one-cycle pulse with cmd_word
   output logic cmd_fixed, // single error corrected
   output logic cmd_bad, // uncorrectable error
   output logic [1:0] word_len, // latched word length code
   output logic ham_on, // hamming in use
   output logic cfg_error, // unsupported strap setting
   awf_link_if.dev link // serial link
);
   localparam int WIDX_W = $clog2(NCH + 2);
   localparam logic [WIDX_W-1:0] LAST_WORD = WIDX_W'(NCH);
   localparam logic [WIDX_W-1:0] PAST_WORD = WIDX_W'(NCH + 1);

   generate
      if (NCH < 1 || NCH > 8) begin : g_bad_nch
         $error("awf_device: NCH must be 1 to 8");
      end
   endgenerate

   logic [3:0] strap_s1_reg;
   logic [3:0] strap_s2_reg;
   logic [1:0] settle_reg;
   logic strap_done_reg;
   awf_wl_t wl_reg;
   logic ham_reg;
   logic cfg_err_reg;
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic rdy_s1_reg;
   logic rdy_s2_reg;
   logic rdy_s3_reg;
   logic [STAT_W-1:0] cmd_reg;
   logic valid_reg;
   logic fixed_reg;
   logic bad_reg;
   logic [WORD_MSB:0] img_reg [0:NCH];
   logic [5:0] tx_bit_reg;
   logic [WIDX_W-1:0] tx_word_reg;
   logic dout_reg;
   logic oe_reg;
   logic [5:0] rx_bit_reg;
   logic rx_done_reg;
   logic [WORD_MSB:0] rx_word_reg;
   logic [5:0] wlb;
   awf_dec_t dec;

   assign wlb = wl_bits(wl_reg);
   assign dec = split_word(rx_word_reg, wl_reg, ham_reg);

   always_ff @(posedge mclk) begin
      if (rst) begin
         strap_s1_reg <= 4'h0;
         strap_s2_reg <= 4'h0;
      end else begin
         strap_s1_reg <= {word_length_strap_level, word_length_strap_float,
                          protection_enable_strap_level, protection_enable_strap_float};
         strap_s2_reg <= strap_s1_reg;
      end
   end

   // [RULE19] latch straps once
   always_ff @(posedge mclk) begin
      if (rst) begin
         settle_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         wl_reg <= AWF_WL16;
         ham_reg <= 1'b0;
         cfg_err_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         settle_reg <= settle_reg + 2'h1;
         if (settle_reg == 2'(STRAP_SETTLE - 1)) begin
            strap_done_reg <= 1'b1;
            wl_reg <= strap_s2_reg[2] ? AWF_WL16 : (strap_s2_reg[3] ? AWF_WL32 : AWF_WL24);
            // [RULE10] [RULE11] protection strap check
            if (strap_s2_reg[0] || (strap_s2_reg[1] && strap_s2_reg[2])) begin
               cfg_err_reg <= 1'b1;
               ham_reg <= 1'b0;
            end else begin
               ham_reg <= strap_s2_reg[1];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         rdy_s1_reg <= 1'b0;
         rdy_s2_reg <= 1'b0;
         rdy_s3_reg <= 1'b0;
      end else begin
         cs_s1_reg <= link.cs_n;
         cs_s2_reg <= cs_s1_reg;
         rdy_s1_reg <= rx_done_reg;
         rdy_s2_reg <= rdy_s1_reg;
         rdy_s3_reg <= rdy_s2_reg;
      end
   end

   // frame image is refreshed only while the link is idle, so the link side sees stable words
   genvar g;
   generate
      for (g = 0; g <= NCH; g++) begin : g_img
         logic [DATA_N-1:0] fld;
         if (g == 0) begin : g_stat
            // [RULE3] [RULE12] status padded with zeros
            assign fld = {status_word, 8'h00};
         end else begin : g_chan
            // [RULE4] [RULE7] [RULE8] clipped results pass through
            assign fld = samples[(g-1)*SAMPLE_W +: SAMPLE_W];
         end
         always_ff @(posedge mclk) begin
            if (rst) begin
               img_reg[g] <= '0;
            end else if (strap_done_reg && cs_s2_reg) begin
               // [RULE5] [RULE6] [RULE9] [RULE13] [RULE14] [RULE17] [RULE20] [RULE21] word formatting
               img_reg[g] <= build_word(fld, wl_reg, ham_reg);
            end
         end
      end
   endgenerate

   // [RULE1] [RULE15] [RULE16] [RULE22] decode command, strip byte
   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_reg <= '0;
         valid_reg <= 1'b0;
         fixed_reg <= 1'b0;
         bad_reg <= 1'b0;
      end else begin
         valid_reg <= rdy_s2_reg && !rdy_s3_reg;
         if (rdy_s2_reg && !rdy_s3_reg) begin
            cmd_reg <= dec.field[DATA_N-1:8];
            fixed_reg <= dec.sgl;
            bad_reg <= dec.dbl;
         end
      end
   end

   // link side: cs_n high ends the frame, since sclk may stop outside frames.
   // wl_reg is only read here after the straps are latched and never changes again.
   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         tx_bit_reg <= 6'h00;
         tx_word_reg <= '0;
         dout_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= 1'b1;
         // [RULE18] msb first, status word first
         dout_reg <= (tx_word_reg <= LAST_WORD) ? img_reg[tx_word_reg][WORD_MSB - int'(tx_bit_reg)] : 1'b0;
         if (tx_bit_reg == wlb - 6'h01) begin
            tx_bit_reg <= 6'h00;
            if (tx_word_reg != PAST_WORD) begin
               tx_word_reg <= tx_word_reg + 1'b1;
            end
         end else begin
            tx_bit_reg <= tx_bit_reg + 6'h01;
         end
      end
   end

   // only the first word is taken; the zero fill behind it is ignored
   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         rx_bit_reg <= 6'h00;
         rx_done_reg <= 1'b0;
         rx_word_reg <= '0;
      end else if (!rx_done_reg) begin
         rx_word_reg[WORD_MSB - int'(rx_bit_reg)] <= link.din;
         if (rx_bit_reg == wlb - 6'h01) begin
            rx_done_reg <= 1'b1;
         end else begin
            rx_bit_reg <= rx_bit_reg + 6'h01;
         end
      end
   end

   assign link.dout = dout_reg;
   assign link.dout_oe = oe_reg;
   assign cmd_word = cmd_reg;
   assign cmd_valid = valid_reg;
   assign cmd_fixed = fixed_reg;
   assign cmd_bad = bad_reg;
   assign word_len = wl_reg;
   assign ham_on = ham_reg;
   assign cfg_error = cfg_err_reg;
endmodule : awf_device
`default_nettype wire

// *** awf_host.sv ***
`default_nettype none
module awf_host
   import awf_pkg::*;
#(
   parameter int NCH = 4,
   parameter int SCLK_HALF = 4
) (
   input wire logic mclk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic [1:0] wl_sel, // word length code, must match far end
   input wire logic ham_en, // hamming in use, must match far end
   input wire logic start, // pulse: run one frame
   input wire logic [STAT_W-1:0] cmd, // command for the frame
   output logic busy, // frame in progress
   output logic [DATA_N-1:0] rx_field, // received word content, corrected
   output logic [3:0] rx_index, // 0 status, then channels
   output logic rx_valid, // one-cycle pulse with rx_field
   output logic rx_fixed, // single error corrected
   output logic rx_bad, // uncorrectable error
   awf_link_if.host link // serial link
);
   typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD} awf_hst_t;

   // dout passes two flops, so each sclk half must outlast the synchroniser
   generate
      if (SCLK_HALF < 3 || SCLK_HALF > 255 || NCH < 1 || NCH > 8) begin : g_bad_par
         $error("awf_host: SCLK_HALF 3..255 and NCH 1..8 required");
      end
   endgenerate

   localparam logic [7:0] HALF_END = 8'(SCLK_HALF - 1);
   localparam logic [7:0] SETUP_END = 8'(CS_SETUP_CYC - 1);
   localparam logic [7:0] HOLD_END = 8'(CS_HOLD_CYC - 1);
   localparam logic [3:0] LAST_WORD = 4'(NCH);

   awf_hst_t state_reg;
   logic [7:0] cnt_reg;
   logic [5:0] bit_reg;
   logic [3:0] word_reg;
   logic sclk_reg;
   logic cs_n_reg;
   logic din_reg;
   logic [WORD_MSB:0] tx_reg;
   logic [WORD_MSB:0] rx_sh_reg;
   awf_wl_t wl_reg;
   logic ham_reg;
   logic dq1_reg;
   logic dq2_reg;
   logic word_end_reg;
   logic [3:0] end_idx_reg;
   logic [DATA_N-1:0] field_reg;
   logic valid_reg;
   logic fixed_reg;
   logic bad_reg;
   logic [5:0] wlb;
   awf_dec_t dec;

   assign wlb = wl_bits(wl_reg);
   assign dec = split_word(rx_sh_reg, wl_reg, ham_reg);

   always_ff @(posedge mclk) begin
      if (rst) begin
         dq1_reg <= 1'b0;
         dq2_reg <= 1'b0;
      end else begin
         dq1_reg <= link.dout_line;
         dq2_reg <= dq1_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= H_IDLE;
         cnt_reg <= 8'h00;
         bit_reg <= 6'h00;
         word_reg <= 4'h0;
         sclk_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         din_reg <= 1'b0;
         tx_reg <= '0;
         rx_sh_reg <= '0;
         wl_reg <= AWF_WL16;
         ham_reg <= 1'b0;
         word_end_reg <= 1'b0;
         end_idx_reg <= 4'h0;
      end else begin
         word_end_reg <= 1'b0;
         case (state_reg)
            H_IDLE: begin
               if (start) begin
                  wl_reg <= awf_wl_t'(wl_sel);
                  ham_reg <= ham_en;
                  // [RULE1] [RULE2] [RULE13] command word first
                  tx_reg <= build_word({cmd, 8'h00}, awf_wl_t'(wl_sel), ham_en);
                  cs_n_reg <= 1'b0;
                  cnt_reg <= 8'h00;
                  bit_reg <= 6'h00;
                  word_reg <= 4'h0;
                  state_reg <= H_SETUP;
               end
            end
            H_SETUP: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == SETUP_END) begin
                  cnt_reg <= 8'h00;
                  state_reg <= H_LOW;
               end
            end
            H_LOW: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == HALF_END) begin
                  cnt_reg <= 8'h00;
                  sclk_reg <= 1'b1;
                  din_reg <= tx_reg[WORD_MSB - int'(bit_reg)];
                  state_reg <= H_HIGH;
               end
            end
            H_HIGH: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == HALF_END) begin
                  cnt_reg <= 8'h00;
                  sclk_reg <= 1'b0;
                  if (bit_reg == 6'h00) begin
                     rx_sh_reg <= {dq2_reg, 31'h0};
                  end else begin
                     rx_sh_reg[WORD_MSB - int'(bit_reg)] <= dq2_reg;
                  end
                  if (bit_reg == wlb - 6'h01) begin
                     bit_reg <= 6'h00;
                     word_end_reg <= 1'b1;
                     end_idx_reg <= word_reg;
                     // zero fill words encode to all zeros, hamming byte included
                     tx_reg <= '0;
                     word_reg <= word_reg + 4'h1;
                     state_reg <= (word_reg == LAST_WORD) ? H_HOLD : H_LOW;
                  end else begin
                     bit_reg <= bit_reg + 6'h01;
                     state_reg <= H_LOW;
                  end
               end
            end
            H_HOLD: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == HOLD_END) begin
                  cnt_reg <= 8'h00;
                  cs_n_reg <= 1'b1;
                  din_reg <= 1'b0;
                  state_reg <= H_IDLE;
               end
            end
            default: begin
               state_reg <= H_IDLE;
            end
         endcase
      end
   end

   // [RULE15] [RULE22] check each received word
   always_ff @(posedge mclk) begin
      if (rst) begin
         field_reg <= '0;
         valid_reg <= 1'b0;
         fixed_reg <= 1'b0;
         bad_reg <= 1'b0;
      end else begin
         valid_reg <= word_end_reg;
         if (word_end_reg) begin
            field_reg <= dec.field;
            fixed_reg <= dec.sgl;
            bad_reg <= dec.dbl;
         end
      end
   end

   logic busy_reg;
   logic [3:0] idx_reg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         busy_reg <= 1'b0;
         idx_reg <= 4'h0;
      end else begin
         busy_reg <= (state_reg != H_IDLE) || start;
         if (word_end_reg) begin
            idx_reg <= end_idx_reg;
         end
      end
   end

   assign link.sclk = sclk_reg;
   assign link.cs_n = cs_n_reg;
   assign link.din = din_reg;
   assign busy = busy_reg;
   assign rx_field = field_reg;
   assign rx_index = idx_reg;
   assign rx_valid = valid_reg;
   assign rx_fixed = fixed_reg;
   assign rx_bad = bad_reg;
endmodule : awf_host
`default_nettype wire

// *** awf_link_properties.sv ***
`default_nettype none
module awf_link_properties (
   input wire logic mclk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic sclk, // link clock
   input wire logic cs_n, // frame select
   input wire logic din, // host to device
   input wire logic dout, // device data
   input wire logic dout_oe // device drive enable
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_idle_clk;
      cs_n |-> !sclk;
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("link clock moves outside a frame");
   property p_cs_setup;
      $fell(cs_n) |-> !sclk [*4];
   endproperty
   a_cs_setup: assert property (p_cs_setup) else $error("link clock too soon after select");
   property p_cs_hold;
      $rose(cs_n) |-> !$past(sclk) && !$past(sclk, 4);
   endproperty
   a_cs_hold: assert property (p_cs_hold) else $error("select released too soon");
   property p_cs_gap;
      $rose(cs_n) |-> cs_n [*2];
   endproperty
   a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
   property p_sclk_high;
      $rose(sclk) |-> sclk [*4] ##1 !sclk;
   endproperty
   a_sclk_high: assert property (p_sclk_high) else $error("link clock high phase wrong");
   property p_idle_oe;
      cs_n && $past(cs_n) |-> !dout_oe;
   endproperty
   a_idle_oe: assert property (p_idle_oe) else $error("device drives while deselected");
   property p_oe_rise;
      $rose(sclk) && !cs_n |-> ##[0:3] dout_oe;
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("device not driving in frame");
   property p_din_stable;
      $fell(sclk) |-> $stable(din);
   endproperty
   a_din_stable: assert property (p_din_stable) else $error("host data moves at sample");
   property p_dout_fall;
      $fell(sclk) |-> $stable(dout) && dout_oe;
   endproperty
   a_dout_fall: assert property (p_dout_fall) else $error("device data moves at sample");

   c_frame: cover property ($fell(cs_n));
   c_oe: cover property ($rose(dout_oe));
   c_back: cover property ($rose(cs_n) ##3 !cs_n);
endmodule : awf_link_properties
`default_nettype wire

// *** adc_spi_word_format_hamming_tb.sv ***
`default_nettype none
module adc_spi_word_format_hamming_tb import awf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // strap sets {wl level, wl float, prot level, prot float}; expected {cfg_error, ham_on, word_len}
   localparam logic [3:0] STRAPS [0:6] = '{4'h4, 4'h0, 4'h2, 4'h8, 4'hA, 4'h6, 4'h9};
   localparam logic [3:0] CFGS [0:6] = '{4'h0, 4'h1, 4'h5, 4'h2, 4'h6, 4'h8, 4'hA};
   logic mclk = 1'b0, rst = 1'b1, start = 1'b0, ham_en = 1'b0;
   logic [3:0] strap = 4'h0;
   logic [1:0] wl_sel = 2'h0, word_len;
   logic [15:0] cmd = 16'h0000, status = 16'h0000, cmd_word;
   // full-scale and one-step codes per channel
   logic [95:0] samples = {24'hFFFFFF, 24'h000001, 24'h800000, 24'h7FFFFF};
   logic cmd_valid, cmd_fixed, cmd_bad, ham_on, cfg_error, busy, rx_valid, rx_fixed, rx_bad;
   logic [23:0] rx_field;
   logic [3:0] rx_index;
   logic [23:0] rx_f [0:4];
   logic [31:0] sh, dsh, din_w;
   logic [31:0] wq [$];
   int error_cnt = 0, n_tests = 0, cyc = 0, nb = 16, cnt = 0, rx_n = 0, cv_n = 0, rx_e = 0;

   always #25 mclk = ~mclk;
   awf_link_if awf_link_if_i ();
   awf_device #(.NCH(4)) awf_device_i (.mclk(mclk), .rst(rst), .word_length_strap_level(strap[3]),
      .word_length_strap_float(strap[2]), .protection_enable_strap_level(strap[1]),
      .protection_enable_strap_float(strap[0]), .status_word(status), .samples(samples), .cmd_word(cmd_word),
      .cmd_valid(cmd_valid), .cmd_fixed(cmd_fixed), .cmd_bad(cmd_bad), .word_len(word_len), .ham_on(ham_on),
      .cfg_error(cfg_error), .link(awf_link_if_i));
   awf_host #(.NCH(4), .SCLK_HALF(4)) awf_host_i (.mclk(mclk), .rst(rst), .wl_sel(wl_sel), .ham_en(ham_en),
      .start(start), .cmd(cmd), .busy(busy), .rx_field(rx_field), .rx_index(rx_index), .rx_valid(rx_valid),
      .rx_fixed(rx_fixed), .rx_bad(rx_bad), .link(awf_link_if_i));
   awf_link_properties awf_link_properties_i (.mclk(mclk), .rst(rst), .sclk(awf_link_if_i.sclk),
      .cs_n(awf_link_if_i.cs_n), .din(awf_link_if_i.din), .dout(awf_link_if_i.dout),
      .dout_oe(awf_link_if_i.dout_oe));

   always @(posedge mclk) begin
      cyc++;
      if (rx_valid === 1'b1) begin
         rx_f[rx_index] = rx_field;
         rx_e += int'((rx_fixed !== 1'b0) || (rx_bad !== 1'b0));
         rx_n++;
      end
      if (cmd_valid === 1'b1) cv_n++;
      if (cyc == 40000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // wire monitor: both lines are sampled on the falling link clock
   always @(negedge awf_link_if_i.sclk) begin
      if (awf_link_if_i.cs_n === 1'b0) begin
         sh = {sh[30:0], awf_link_if_i.dout_line};
         dsh = {dsh[30:0], awf_link_if_i.din};
         cnt++;
         if (cnt == nb) begin
            wq.push_back(sh << (32 - nb));
            if (wq.size() == 1) din_w = dsh << (32 - nb);
            cnt = 0;
         end
      end
   end
   always @(negedge awf_link_if_i.cs_n) cnt = 0;

   // independent encoder: position 3 holds data bit 23, powers of two hold parity
   function automatic logic [7:0] hb(input logic [23:0] d);
      logic [4:0] p;
      int i;
      p = 5'h00;
      i = 23;
      for (int pos = 3; pos < 30; pos++) begin
         if ((pos & (pos - 1)) != 0) begin
            for (int k = 0; k < 5; k++) if (pos[k]) p[k] ^= d[i];
            i--;
         end
      end
      return {p, ^d ^ ^p, ^d ^ ^p, 1'b0};
   endfunction : hb

   function automatic logic [31:0] exp_word(input logic [23:0] f);
      case (wl_sel)
         2'h0: return {f[23:8], 16'h0000};
         2'h1: return ham_en ? {f[23:8], hb({f[23:8], 8'h00}), 8'h00} : {f, 8'h00};
         default: return {f, ham_en ? hb(f) : 8'h00};
      endcase
   endfunction : exp_word

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // decoder: every single flip from bit 2 up is mended, a double flip is flagged
   task automatic decode_test();
      awf_dec_t r;
      logic [31:0] w;
      w = {24'hC3A51E, hb(24'hC3A51E)};
      for (int b = 2; b < 32; b++) begin
         r = split_word(w ^ (32'h00000001 << b), AWF_WL32, 1'b1);
         check("fix_field", r.field, 24'hC3A51E);
         check("fix_flags", {r.sgl, r.dbl}, 32'h00000002);
      end
      r = split_word(w ^ 32'h80000100, AWF_WL32, 1'b1);
      check("dbl_flags", {r.sgl, r.dbl}, 32'h00000001);
      $display("decoder test done");
   endtask : decode_test

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : tick

   // returns as soon as busy drops, so consecutive calls run frames back to back
   task automatic frame(input logic [15:0] c);
      logic [23:0] f;
      wq.delete();
      rx_f = '{default: 'x};
      rx_n = 0;
      cv_n = 0;
      rx_e = 0;
      cmd = c;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      while (busy === 1'b1) tick(1);
      check("cmd_word", cmd_word, c);
      check("cmd_err", {cmd_fixed, cmd_bad}, 32'h0);
      check("cmd_pulses", cv_n, 1);
      check("din_word0", din_w, exp_word({c, 8'h00}));
      check("rx_words", rx_n, 5);
      check("wire_words", wq.size(), 5);
      check("rx_err", rx_e, 0);
      for (int k = 0; k < 5; k++) begin
         f = (k == 0) ? {status, 8'h00} : samples[24*k-24 +: 24];
         check("wire_word", wq[k], exp_word(f));
         check("rx_field", rx_f[k], (wl_sel == 2'h0 || (wl_sel == 2'h1 && ham_en)) ? {f[23:8], 8'h00} : f);
      end
   endtask : frame

   initial begin
      decode_test();
      for (int c = 0; c < 7; c++) begin
         strap = STRAPS[c];
         rst = 1'b1;
         tick(6);
         rst = 1'b0;
         tick(12);
         check("strap_cfg", {cfg_error, ham_on, word_len}, CFGS[c]);
         strap = ~strap;
         {ham_en, wl_sel} = CFGS[c][2:0];
         nb = (wl_sel == 2'h0) ? 16 : (wl_sel == 2'h1) ? 24 : 32;
         status = 16'h1234 + 16'(c);
         if (!CFGS[c][3]) begin
            frame(16'hA5C3 ^ 16'(c));
            frame(16'h5A3C + 16'(c));
         end
         check("strap_hold", {cfg_error, ham_on, word_len}, CFGS[c]);
         $display("config %0d done", c);
      end
      give_verdict();
   end
endmodule : adc_spi_word_format_hamming_tb
`default_nettype wire
